// ===== esm_crc16.sv
// package of shared constants and the bit-serial crc-16 generator
// assumes one clock; bits arrive lsb first, one per shift strobe
package esm_pkg;
  localparam logic [7:0]  CMD_WRITE_SP   = 8'h0F;
  localparam logic [7:0]  CMD_READ_SP    = 8'hAA;
  localparam logic [7:0]  CMD_COPY_SP    = 8'h55;
  localparam logic [7:0]  CMD_READ_MEM   = 8'hF0;
  localparam int          MEM_BYTES      = 144;
  localparam int          SP_BYTES       = 8;
  localparam logic [7:0]  MEM_LAST       = 8'h8F;
  localparam logic [7:0]  PROT_BASE      = 8'h80;
  localparam logic [7:0]  COPY_PROT_ADDR = 8'h84;
  localparam logic [7:0]  FACTORY_ADDR   = 8'h85;
  localparam logic [7:0]  USER_LAST      = 8'h87;
  localparam logic [4:0]  REG_ROW        = 5'h10;
  localparam logic [7:0]  LOCK_WP        = 8'h55;
  localparam logic [7:0]  LOCK_EPROM     = 8'hAA;
  localparam logic [7:0]  ERASED         = 8'hFF;
  localparam int          ES_COPY_DONE   = 7;
  localparam int          ES_PARTIAL     = 5;
  localparam logic [7:0]  ES_RESET       = 8'h20;
  localparam logic [2:0]  ROW_END        = 3'h7;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] CRC_INIT       = 16'h0000;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_WS_CRC, ST_RS, ST_CP_AUTH,
    ST_PROG, ST_CP_DONE, ST_FF_STREAM, ST_RM_ADDR, ST_RM_DATA, ST_HALT
  } esm_state_t;
endpackage

`timescale 1ns/1ns
`default_nettype none
module esm_crc16
  import esm_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_clear,
  input  wire logic        i_shift,
  input  wire logic        i_bit,
  output logic      [15:0] o_crc
);
  logic [15:0] crc_ff;
  logic        fb;

  assign fb    = crc_ff[0] ^ i_bit;
  assign o_crc = crc_ff;

  // clear beats shift so a new command never inherits stale bits
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      crc_ff <= CRC_INIT;
    end else if (i_clear) begin
      crc_ff <= CRC_INIT;
    end else if (i_shift) begin
      crc_ff <= (crc_ff >> 1) ^ (fb ? CRC_POLY : 16'h0000);
    end
  end
endmodule
`default_nettype wire

// ===== esm_master.sv
// bus master model: turns bit requests into slot strobes
// assumes the bench calls its tasks; strobes move at the falling edge
`timescale 1ns/1ns
`default_nettype none
module esm_master
  import esm_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_slow,
  output logic      o_wr_slot,
  output logic      o_wr_bit,
  output logic      o_rd_slot
);
  initial begin
    o_wr_slot = 1'b0;
    o_wr_bit  = 1'b0;
    o_rd_slot = 1'b0;
  end
  // each slot opens with its own strobe, never both kinds at once
  task automatic slot(input logic rd, input logic b);
    @(negedge i_mclk);
    o_wr_slot = !rd;
    o_rd_slot = rd;
    o_wr_bit  = rd ? ~o_wr_bit : b;
    @(negedge i_mclk);
    o_wr_slot = 1'b0;
    o_rd_slot = 1'b0;
    // released data line must not keep the last value
    o_wr_bit  = ~o_wr_bit;
    // slow master waits three more cycles between slots with both strobes low
    if (i_slow) repeat (3) @(negedge i_mclk);
  endtask
  task automatic send(input logic [7:0] v);
    for (int i = 0; i < 8; i++) slot(1'b0, v[i]);
  endtask
  task automatic rd_slots(input int n);
    for (int i = 0; i < n; i++) slot(1'b1, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== esm_mem_cmd.sv
// memory-function command layer of a single-wire eeprom slave
// assumes a slot layer upstream that turns bus slots into one-cycle strobes
// How it works
// RQ1 - write-scratchpad takes two address bytes, low first, then data bytes
// RQ2 - data lands from start offset; end offset starts there, steps per full byte
// RQ3 - unaligned or short writes are taken, but a later copy is refused
// RQ4 - crc cleared, then command, address and data shifted in as received
// RQ5 - at end offset seven, sixteen read slots return the inverted crc
// RQ6 - write-protected target loads existing memory into scratchpad
// RQ7 - eprom-mode page loads transmitted byte anded with memory byte
// RQ8 - read-scratchpad sends address low, high, status, then stored bytes
// RQ9 - after stored bytes the inverted crc of the sent bytes follows
// RQ10 - reading past that crc returns ones
// RQ11 - status shows partial flag; copy-done with no partial means write unseen
// RQ12 - copy takes three authorization bytes compared with address and status
// RQ13 - good copy sets copy-done and programs all eight bytes
// RQ14 - after a copy, read slots return alternating zero and one
// RQ15 - partial flag or copy protection refuses copy, copy-done stays clear
// RQ16 - disturbed copy returns all ones until bus reset
// RQ17 - read-memory takes two address bytes, streams memory, ones past the end
// RQ18 - read-memory leaves address, status and scratchpad alone
// RQ19 - standard speed by default, fast only once explicitly set
// RQ20 - master leaves the bus idle high when pausing; esm_master inverts o_wr_bit on release instead
// RQ21 - access order: reset, rom command, memory command, data
// RQ22 - master opens every slot with a falling edge
// RQ23 - status bit 7 copy-done, bit 5 partial, bits 2..0 end offset
// RQ24 - protection byte 55h write-protects page, AAh selects eprom mode
// RQ25 - copy-protect byte 55h/AAh blocks register row and protected pages
// RQ26 - any new scratchpad write clears copy-done
// RQ27 - unknown command: stay silent until the next bus reset
`timescale 1ns/1ns
`default_nettype none
module esm_mem_cmd
  import esm_pkg::*;
#(
  parameter logic [7:0] FACTORY_BYTE = 8'h00 // arbitrary factory setting
)
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_mem_start,
  input  wire logic       i_bus_reset,
  input  wire logic       i_long_reset,
  input  wire logic       i_od_set,
  input  wire logic       i_wr_slot,
  input  wire logic       i_wr_bit,
  input  wire logic       i_rd_slot,
  input  wire logic       i_supply_low,
  input  wire logic       i_power_lost,
  output logic            o_rd_valid,
  output logic            o_rd_bit,
  output logic            o_fast_speed_flag,
  output logic      [7:0] o_status
);
  esm_state_t  state_ff;
  logic [7:0]  mem_ff [0:MEM_BYTES-1];
  logic [7:0]  sp_ff  [0:SP_BYTES-1];
  logic [7:0]  target_addr_low_ff;
  logic [7:0]  target_addr_high_ff;
  logic [7:0]  es_ff;
  logic [7:0]  rx_sr_ff;
  logic [2:0]  rx_cnt_ff;
  logic [1:0]  rx_idx_ff;
  logic [2:0]  tx_cnt_ff;
  logic [4:0]  tx_idx_ff;
  logic [15:0] rm_addr_ff;
  logic        first_ff;
  logic        auth_bad_ff;
  logic        alt_ff;
  logic [2:0]  prog_cnt_ff;
  logic        rd_valid_ff;
  logic        rd_bit_ff;
  logic        fast_speed_flag_ff;

  logic        byte_done;
  logic [7:0]  rx_byte;
  logic [15:0] ta;
  logic [2:0]  wr_pos;
  logic [15:0] wr_addr;
  logic [7:0]  wr_val;
  logic        wr_open;
  logic [4:0]  rs_crc_idx;
  logic [4:0]  sp_off;
  logic        tx_state;
  logic [7:0]  tx_byte;
  logic        cur_bit;
  logic        addr_valid;
  logic        copy_prot;
  logic        copy_ok;
  logic        crc_clear;
  logic        crc_shift;
  logic        crc_bit;
  logic [15:0] crc;

  assign o_rd_valid        = rd_valid_ff;
  assign o_rd_bit          = rd_bit_ff;
  assign o_fast_speed_flag = fast_speed_flag_ff;
  assign o_status          = es_ff; // RQ23

  function automatic logic is_lock(input logic [7:0] b);
    return (b == LOCK_WP) || (b == LOCK_EPROM);
  endfunction

  function automatic logic [7:0] mem_rd(input logic [15:0] a);
    return (a[15:8] == 8'h00 && a[7:0] <= MEM_LAST) ? mem_ff[a[7:0]] : ERASED;
  endfunction

  // unmapped and reserved targets act as protected so they never change
  function automatic logic is_wp(input logic [15:0] a);
    if (a[15:8] != 8'h00 || a[7:0] > USER_LAST) return 1'b1;
    if (a[7:0] < PROT_BASE) return mem_ff[PROT_BASE + {6'h00, a[6:5]}] == LOCK_WP; // RQ24
    if (a[7:0] <= COPY_PROT_ADDR) return is_lock(mem_ff[a[7:0]]);
    if (a[7:0] == FACTORY_ADDR) return 1'b1;
    return mem_ff[FACTORY_ADDR] == LOCK_EPROM;
  endfunction

  function automatic logic is_eprom(input logic [15:0] a);
    return a[15:7] == 9'h000 && mem_ff[PROT_BASE + {6'h00, a[6:5]}] == LOCK_EPROM; // RQ24
  endfunction

  assign byte_done = i_wr_slot && rx_cnt_ff == 3'h7;
  assign rx_byte   = {i_wr_bit, rx_sr_ff[7:1]};
  assign ta        = {target_addr_high_ff, target_addr_low_ff};
  assign wr_pos    = first_ff ? target_addr_low_ff[2:0] : es_ff[2:0] + 3'h1; // RQ2
  assign wr_addr   = {target_addr_high_ff, target_addr_low_ff[7:3], wr_pos};
  assign wr_open   = first_ff || es_ff[2:0] != ROW_END;
  assign rs_crc_idx = 5'h03 + {2'h0, es_ff[2:0] - target_addr_low_ff[2:0]} + 5'h01; // RQ9
  assign sp_off    = tx_idx_ff - 5'h03;
  assign tx_state  = state_ff inside {ST_WS_CRC, ST_RS, ST_CP_DONE, ST_FF_STREAM, ST_RM_DATA};

  always_comb begin
    if (is_wp(wr_addr)) begin
      wr_val = mem_rd(wr_addr); // RQ6
    end else if (is_eprom(wr_addr)) begin
      wr_val = rx_byte & mem_rd(wr_addr); // RQ7
    end else begin
      wr_val = rx_byte;
    end
  end

  assign addr_valid = target_addr_high_ff == 8'h00 && target_addr_low_ff[2:0] == 3'h0 &&
                      target_addr_low_ff <= USER_LAST; // RQ3
  assign copy_prot  = is_lock(mem_ff[COPY_PROT_ADDR]) &&
                      (target_addr_low_ff[7:3] == REG_ROW || is_wp(ta)); // RQ25
  assign copy_ok    = !auth_bad_ff && rx_byte == es_ff && addr_valid &&
                      !es_ff[ES_PARTIAL] && !copy_prot; // RQ12 RQ13 RQ15

  always_comb begin
    case (state_ff)
      ST_WS_CRC: begin
        if (tx_idx_ff == 5'h00) tx_byte = ~crc[7:0]; // RQ5
        else if (tx_idx_ff == 5'h01) tx_byte = ~crc[15:8];
        else tx_byte = ERASED;
      end
      ST_RS: begin
        if (tx_idx_ff == 5'h00) tx_byte = target_addr_low_ff; // RQ8
        else if (tx_idx_ff == 5'h01) tx_byte = target_addr_high_ff;
        else if (tx_idx_ff == 5'h02) tx_byte = es_ff;
        else if (tx_idx_ff < rs_crc_idx) tx_byte = sp_ff[target_addr_low_ff[2:0] + sp_off[2:0]];
        else if (tx_idx_ff == rs_crc_idx) tx_byte = ~crc[7:0]; // RQ9
        else if (tx_idx_ff == rs_crc_idx + 5'h01) tx_byte = ~crc[15:8];
        else tx_byte = ERASED; // RQ10
      end
      ST_RM_DATA: tx_byte = mem_rd(rm_addr_ff); // RQ17
      default:    tx_byte = ERASED; // RQ16
    endcase
  end

  assign cur_bit = (state_ff == ST_CP_DONE) ? alt_ff : tx_byte[tx_cnt_ff];

  // read-scratchpad crc covers only the bytes this read sends out
  assign crc_clear = i_mem_start || (state_ff == ST_CMD && byte_done && rx_byte == CMD_READ_SP); // RQ4
  assign crc_shift = (i_wr_slot && state_ff inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA}) ||
                     (i_rd_slot && state_ff == ST_RS && tx_idx_ff < rs_crc_idx); // RQ4 RQ9
  assign crc_bit   = (state_ff == ST_RS) ? cur_bit : i_wr_bit;

  esm_crc16 u_crc (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_clear (crc_clear),
    .i_shift (crc_shift),
    .i_bit   (crc_bit),
    .o_crc   (crc)
  );

  // sequencing; a bus reset always returns to idle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
    end else if (i_bus_reset) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: if (i_mem_start) state_ff <= ST_CMD; // RQ21
        ST_CMD: begin
          if (byte_done) begin
            case (rx_byte)
              CMD_WRITE_SP: state_ff <= ST_WS_ADDR; // RQ1
              CMD_READ_SP:  state_ff <= ST_RS;
              CMD_COPY_SP:  state_ff <= ST_CP_AUTH;
              CMD_READ_MEM: state_ff <= ST_RM_ADDR;
              default:      state_ff <= ST_HALT; // RQ27
            endcase
          end
        end
        ST_WS_ADDR: if (byte_done && rx_idx_ff == 2'h1) state_ff <= ST_WS_DATA;
        ST_WS_DATA: if (byte_done && wr_open && wr_pos == ROW_END) state_ff <= ST_WS_CRC; // RQ5
        ST_CP_AUTH: begin
          if (byte_done && rx_idx_ff == 2'h2) state_ff <= copy_ok ? ST_PROG : ST_HALT; // RQ15
        end
        ST_PROG: begin
          if (i_supply_low) state_ff <= ST_FF_STREAM; // RQ16
          else if (prog_cnt_ff == ROW_END) state_ff <= ST_CP_DONE;
        end
        ST_RM_ADDR: if (byte_done && rx_idx_ff == 2'h1) state_ff <= ST_RM_DATA;
        default: state_ff <= state_ff;
      endcase
    end
  end

  // incoming bits, lsb first; only whole bytes ever act
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_sr_ff  <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_idx_ff <= 2'h0;
    end else if (i_bus_reset || i_mem_start) begin
      rx_cnt_ff <= 3'h0;
      rx_idx_ff <= 2'h0;
    end else if (i_wr_slot) begin
      rx_sr_ff  <= rx_byte;
      rx_cnt_ff <= rx_cnt_ff + 3'h1;
      if (byte_done) rx_idx_ff <= (state_ff == ST_CMD) ? 2'h0 : rx_idx_ff + 2'h1;
    end
  end

  // outgoing position, alternating pattern and read-memory address
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_cnt_ff  <= 3'h0;
      tx_idx_ff  <= 5'h00;
      alt_ff     <= 1'b0;
      rm_addr_ff <= 16'h0000;
    end else if (i_mem_start) begin
      tx_cnt_ff <= 3'h0;
      tx_idx_ff <= 5'h00;
      alt_ff    <= 1'b0;
    end else begin
      if (i_rd_slot && tx_state) begin
        tx_cnt_ff <= tx_cnt_ff + 3'h1;
        if (tx_cnt_ff == 3'h7 && tx_idx_ff != 5'h1F) tx_idx_ff <= tx_idx_ff + 5'h01;
        if (state_ff == ST_CP_DONE) alt_ff <= ~alt_ff; // RQ14
        if (state_ff == ST_RM_DATA && tx_cnt_ff == 3'h7 && rm_addr_ff[7:0] <= MEM_LAST) begin
          rm_addr_ff <= rm_addr_ff + 16'h0001; // RQ17
        end
      end
      if (state_ff == ST_RM_ADDR && byte_done) begin
        if (rx_idx_ff == 2'h0) rm_addr_ff[7:0] <= rx_byte;
        else rm_addr_ff[15:8] <= rx_byte;
      end
    end
  end

  // answer one cycle after each read slot; silent states leave the bus released
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_valid_ff <= 1'b0;
      rd_bit_ff   <= 1'b1;
    end else begin
      rd_valid_ff <= i_rd_slot && tx_state && !i_bus_reset; // RQ27
      if (i_rd_slot && tx_state) rd_bit_ff <= cur_bit;
    end
  end

  // address registers, status and scratchpad; read-memory never touches them
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      target_addr_low_ff  <= 8'h00;
      target_addr_high_ff <= 8'h00;
      es_ff               <= ES_RESET;
      first_ff            <= 1'b0;
      auth_bad_ff         <= 1'b0;
      for (int i = 0; i < SP_BYTES; i++) sp_ff[i] <= ERASED;
    end else begin
      if (state_ff == ST_WS_ADDR && byte_done) begin
        if (rx_idx_ff == 2'h0) begin
          target_addr_low_ff <= rx_byte; // RQ1
        end else begin
          target_addr_high_ff        <= rx_byte;
          es_ff[2:0]                 <= target_addr_low_ff[2:0]; // RQ2
          es_ff[ES_COPY_DONE]        <= 1'b0; // RQ26
          es_ff[ES_PARTIAL]          <= 1'b1; // RQ11
          first_ff                   <= 1'b1;
        end
      end
      if (state_ff == ST_WS_DATA && byte_done && wr_open) begin
        sp_ff[wr_pos] <= wr_val;
        es_ff[2:0]    <= wr_pos; // RQ2
        first_ff      <= 1'b0;
        if (wr_pos == ROW_END) es_ff[ES_PARTIAL] <= 1'b0; // RQ11
      end
      if (state_ff == ST_CMD && byte_done) auth_bad_ff <= 1'b0;
      if (state_ff == ST_CP_AUTH && byte_done) begin
        if (rx_idx_ff == 2'h0) auth_bad_ff <= rx_byte != target_addr_low_ff; // RQ12
        if (rx_idx_ff == 2'h1) auth_bad_ff <= auth_bad_ff || rx_byte != target_addr_high_ff;
        if (rx_idx_ff == 2'h2 && copy_ok) es_ff[ES_COPY_DONE] <= 1'b1; // RQ13
      end
      // power loss marks the scratchpad invalid and wins over any clear
      if (i_power_lost) es_ff[ES_PARTIAL] <= 1'b1; // RQ11
    end
  end

  // array programming, one byte per cycle over the whole row
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prog_cnt_ff <= 3'h0;
      for (int i = 0; i < MEM_BYTES; i++) mem_ff[i] <= ERASED;
      mem_ff[FACTORY_ADDR] <= FACTORY_BYTE;
    end else if (state_ff == ST_PROG && !i_supply_low && !i_bus_reset) begin
      mem_ff[{target_addr_low_ff[7:3], prog_cnt_ff}] <= sp_ff[prog_cnt_ff]; // RQ13
      prog_cnt_ff <= prog_cnt_ff + 3'h1;
    end else begin
      prog_cnt_ff <= 3'h0;
    end
  end

  // speed: only an explicit set selects fast; a long reset pulse restores standard
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fast_speed_flag_ff <= 1'b0;
    end else if (i_od_set) begin
      fast_speed_flag_ff <= 1'b1; // RQ19
    end else if (i_bus_reset && i_long_reset) begin
      fast_speed_flag_ff <= 1'b0;
    end
  end

  logic cp_seen_ff;
  logic cp_last_ff;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cp_seen_ff <= 1'b0;
      cp_last_ff <= 1'b0;
    end else if (state_ff != ST_CP_DONE) begin
      cp_seen_ff <= 1'b0;
    end else if (rd_valid_ff) begin
      cp_seen_ff <= 1'b1;
      cp_last_ff <= rd_bit_ff;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_speed_explicit;
    $rose(o_fast_speed_flag) |-> $past(i_od_set);
  endproperty
  a_speed_explicit: assert property (p_speed_explicit) else $error("fast speed without set"); // RQ19

  property p_write_clears_done;
    (state_ff == ST_WS_ADDR && byte_done && rx_idx_ff == 2'h1 && !i_bus_reset)
      |=> !es_ff[ES_COPY_DONE] && state_ff == ST_WS_DATA;
  endproperty
  a_write_clears_done: assert property (p_write_clears_done) else $error("copy-done kept"); // RQ26

  property p_end_not_below_start;
    (state_ff inside {ST_WS_DATA, ST_WS_CRC} && !first_ff)
      |-> es_ff[2:0] >= target_addr_low_ff[2:0];
  endproperty
  a_end_not_below_start: assert property (p_end_not_below_start) else $error("end offset low"); // RQ2

  property p_ones_after_crc;
    (state_ff == ST_RS && i_rd_slot && tx_idx_ff > rs_crc_idx + 5'h01 && !i_bus_reset)
      |=> o_rd_valid && o_rd_bit;
  endproperty
  a_ones_after_crc: assert property (p_ones_after_crc) else $error("non-one past crc"); // RQ10

  property p_halt_silent;
    (state_ff == ST_HALT) |=> !o_rd_valid;
  endproperty
  a_halt_silent: assert property (p_halt_silent) else $error("answer after unknown cmd"); // RQ27

  property p_alternate;
    (state_ff == ST_CP_DONE && o_rd_valid && cp_seen_ff) |-> o_rd_bit != cp_last_ff;
  endproperty
  a_alternate: assert property (p_alternate) else $error("pattern not alternating"); // RQ14

  property p_refuse_partial;
    (state_ff == ST_CP_AUTH && byte_done && rx_idx_ff == 2'h2 && es_ff[ES_PARTIAL])
      |=> !es_ff[ES_COPY_DONE] && state_ff != ST_PROG;
  endproperty
  a_refuse_partial: assert property (p_refuse_partial) else $error("copy despite partial"); // RQ15

  property p_readmem_keeps;
    (state_ff == ST_RM_DATA && !i_power_lost)
      |=> $stable(target_addr_low_ff) && $stable(target_addr_high_ff) && $stable(es_ff);
  endproperty
  a_readmem_keeps: assert property (p_readmem_keeps) else $error("read-memory changed regs"); // RQ18

  property p_prog_bounded;
    $rose(state_ff == ST_PROG) |-> es_ff[ES_COPY_DONE] ##[1:9] (state_ff != ST_PROG);
  endproperty
  a_prog_bounded: assert property (p_prog_bounded) else $error("programming overran"); // RQ13

  property p_disturbed_ones;
    (state_ff == ST_FF_STREAM && i_rd_slot && !i_bus_reset) |=> o_rd_valid && o_rd_bit;
  endproperty
  a_disturbed_ones: assert property (p_disturbed_ones) else $error("zero after disturbed copy"); // RQ16
endmodule
`default_nettype wire

// ===== esm_mem_cmd_tb.sv
// self-checking bench for the memory-command layer
// assumes esm_master makes the slots; answers are checked from a queue
`timescale 1ns/1ns
`default_nettype none
module esm_mem_cmd_tb;
  import esm_pkg::*;
  logic        i_mclk, i_rst, i_mem_start, i_bus_reset, i_long_reset, i_od_set;
  logic        i_supply_low, i_power_lost, slow, wr_slot, wr_bit, rd_slot;
  logic        o_rd_valid, o_rd_bit, o_fast_speed_flag;
  logic [7:0]  o_status;
  logic [7:0]  d1 [8];
  logic [7:0]  dat [8];
  logic [15:0] crc;
  logic        exp_q [$];
  int          err_count = 0;
  int          total_checks = 0;
  int          seed = 32'h2ab5;

  esm_mem_cmd dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_mem_start(i_mem_start),
    .i_bus_reset(i_bus_reset), .i_long_reset(i_long_reset), .i_od_set(i_od_set),
    .i_wr_slot(wr_slot), .i_wr_bit(wr_bit), .i_rd_slot(rd_slot),
    .i_supply_low(i_supply_low), .i_power_lost(i_power_lost), .o_rd_valid(o_rd_valid),
    .o_rd_bit(o_rd_bit), .o_fast_speed_flag(o_fast_speed_flag), .o_status(o_status));
  esm_master m (.i_mclk(i_mclk), .i_slow(slow), .o_wr_slot(wr_slot), .o_wr_bit(wr_bit),
    .o_rd_slot(rd_slot));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
  task automatic tx(input logic [7:0] v);
    crc = crc8(crc, v);
    m.send(v);
  endtask
  task automatic cmd(input logic [7:0] c);
    @(negedge i_mclk);
    i_mem_start = 1'b1;
    @(negedge i_mclk);
    i_mem_start = 1'b0;
    crc = CRC_INIT;
    tx(c);
  endtask
  task automatic brst(input logic lng);
    @(negedge i_mclk);
    i_bus_reset  = 1'b1;
    i_long_reset = lng;
    @(negedge i_mclk);
    i_bus_reset  = 1'b0;
  endtask
  // note one byte of answers, then open its eight read slots
  task automatic want(input logic [7:0] v);
    crc = crc8(crc, v);
    for (int i = 0; i < 8; i++) exp_q.push_back(v[i]);
    m.rd_slots(8);
  endtask
  task automatic want_crc();
    logic [15:0] c;
    c = ~crc;
    want(c[7:0]);
    want(c[15:8]);
  endtask
  task automatic drain(input logic [7:0] st);
    repeat (4) @(negedge i_mclk);
    check("queue left", 16'(exp_q.size()), 16'h0000);
    check("status", {8'h00, o_status}, {8'h00, st});
  endtask
  task automatic wsp(input logic [15:0] a, input int n);
    cmd(CMD_WRITE_SP);
    tx(a[7:0]);
    tx(a[15:8]);
    for (int i = 0; i < n; i++) tx(dat[i]);
  endtask
  task automatic rsp(input logic [15:0] a, input logic [7:0] st, input int n);
    cmd(CMD_READ_SP);
    crc = CRC_INIT;
    want(a[7:0]);
    want(a[15:8]);
    want(st);
    for (int i = 0; i < n; i++) want(dat[i]);
    want_crc();
    want(ERASED);
  endtask
  task automatic copy(input logic [15:0] a, input logic [7:0] st);
    cmd(CMD_COPY_SP);
    tx(a[7:0]);
    tx(a[15:8]);
    tx(st);
  endtask
  task automatic rnd();
    for (int i = 0; i < 8; i++) dat[i] = 8'($random(seed));
    slow = 1'($random(seed));
  endtask

  // every answer must have been noted beforehand
  always @(negedge i_mclk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected answer", 16'h0001, 16'h0000);
      else check("answer bit", {15'h0000, o_rd_bit}, {15'h0000, exp_q.pop_front()});
    end
  end

  initial begin
    #1000000;
    check("watchdog", 16'h0001, 16'h0000);
    final_report();
  end

  initial begin
    i_rst = 1'b1;
    i_mem_start = 1'b0;
    i_bus_reset = 1'b0;
    i_long_reset = 1'b0;
    i_od_set = 1'b0;
    i_supply_low = 1'b0;
    i_power_lost = 1'b0;
    slow = 1'b0;
    repeat (16) @(negedge i_mclk);
    i_rst = 1'b0;
    drain(ES_RESET);
    check("speed", {15'h0000, o_fast_speed_flag}, 16'h0000);
    rnd();
    d1 = dat;
    wsp(16'h0000, 8);
    want_crc();
    drain(8'h07);
    brst(1'b0);
    rsp(16'h0000, 8'h07, 8);
    drain(8'h07);
    brst(1'b0);
    copy(16'h0000, 8'h07);
    repeat (12) @(negedge i_mclk);
    want(8'hAA);
    drain(8'h87);
    brst(1'b0);
    cmd(CMD_READ_MEM);
    tx(8'h00);
    tx(8'h00);
    for (int i = 0; i < 8; i++) want(d1[i]);
    brst(1'b0);
    cmd(CMD_READ_MEM);
    tx(8'h90);
    tx(8'h00);
    want(ERASED);
    drain(8'h87);
    $display("test write, read and copy done");
    brst(1'b0);
    rnd();
    wsp(16'h0003, 2);
    drain(8'h24);
    brst(1'b0);
    copy(16'h0003, 8'h24);
    m.rd_slots(8);
    drain(8'h24);
    brst(1'b0);
    cmd(8'h33);
    m.rd_slots(8);
    drain(8'h24);
    $display("test refusals done");
    brst(1'b0);
    dat = '{LOCK_EPROM, LOCK_WP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22};
    wsp({8'h00, PROT_BASE}, 8);
    brst(1'b0);
    copy({8'h00, PROT_BASE}, 8'h07);
    repeat (12) @(negedge i_mclk);
    drain(8'h87);
    brst(1'b0);
    rnd();
    wsp(16'h0000, 8);
    for (int i = 0; i < 8; i++) dat[i] = dat[i] & d1[i];
    brst(1'b0);
    rsp(16'h0000, 8'h07, 8);
    brst(1'b0);
    rnd();
    wsp(16'h0020, 8);
    dat = '{default: ERASED};
    brst(1'b0);
    rsp(16'h0020, 8'h07, 8);
    drain(8'h07);
    brst(1'b0);
    dat = '{8'h00, 8'h00, 8'h00, 8'h00, LOCK_WP, 8'h00, 8'h00, 8'h00};
    wsp({8'h00, PROT_BASE}, 8);
    brst(1'b0);
    copy({8'h00, PROT_BASE}, 8'h07);
    repeat (12) @(negedge i_mclk);
    drain(8'h87);
    brst(1'b0);
    wsp({8'h00, PROT_BASE}, 8);
    brst(1'b0);
    copy({8'h00, PROT_BASE}, 8'h07);
    m.rd_slots(8);
    drain(8'h07);
    $display("test protection done");
    brst(1'b0);
    rnd();
    wsp(16'h0040, 8);
    brst(1'b0);
    copy(16'h0040, 8'h07);
    i_supply_low = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_supply_low = 1'b0;
    want(ERASED);
    drain(8'h87);
    i_power_lost = 1'b1;
    @(negedge i_mclk);
    i_power_lost = 1'b0;
    drain(8'hA7);
    i_od_set = 1'b1;
    @(negedge i_mclk);
    i_od_set = 1'b0;
    brst(1'b0);
    check("speed", {15'h0000, o_fast_speed_flag}, 16'h0001);
    brst(1'b1);
    @(negedge i_mclk);
    check("speed", {15'h0000, o_fast_speed_flag}, 16'h0000);
    $display("test abort, power and speed done");
    final_report();
  end
endmodule
`default_nettype wire
